// ### logic/hbgc_defs.vh
// constants for the h-bridge gate control and protection block
`ifndef HBGC_DEFS_VH
`define HBGC_DEFS_VH

`define HBGC_CLK_PERIOD_NS 10
`define HBGC_OFF_NS        20000
`define HBGC_BLANK_NS      16500
`define HBGC_TIMER_W       12

////////////////////////////////////////////////////////////////////////
`define HBGC_ADDR_STATE    12'h000
`define HBGC_ADDR_INT_STAT 12'h004
`define HBGC_ADDR_INT_MASK 12'h008
`define HBGC_ADDR_CTRL     12'h00c

`define HBGC_RST_INT_MASK  5'h00
`define HBGC_RST_CTRL      1'h0

////////////////////////////////////////////////////////////////////////
`define HBGC_ST_SLEEP      0
`define HBGC_ST_ACTIVE     1
`define HBGC_ST_SC_LATCH   2
`define HBGC_ST_OT_LATCH   3
`define HBGC_ST_UV         4
`define HBGC_ST_OFF_BUSY   5
`define HBGC_ST_BLANK_BUSY 6
`define HBGC_ST_FLAG_N     7
`define HBGC_ST_OUT_A      8
`define HBGC_ST_OUT_B      9
`define HBGC_ST_OUT_OE     10
`define HBGC_ST_FOLD       11
`define HBGC_ST_W          12

`define HBGC_EV_SC         0
`define HBGC_EV_OT         1
`define HBGC_EV_UV         2
`define HBGC_EV_TRIP       3
`define HBGC_EV_CLEAR      4
`define HBGC_EV_W          5

`define HBGC_CTRL_FORCE_OFF 0

`endif

// ### logic/hbgc_sync.v
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module hbgc_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer     i;

  // s1 feeds s2 only; the filter looks at s2 and s3
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// ### logic/hbgc_timer.v
// retriggerable one-shot interval timer
`timescale 1ns/1ps
module hbgc_timer #(
  parameter W   = 12,
  parameter LEN = 1
) (
  input  wire pclk,
  input  wire presetn,
  input  wire load,
  output wire busy
);

  localparam [W-1:0] LEN_W = LEN[W-1:0];

  reg [W-1:0] count_reg;

  assign busy = (count_reg != {W{1'b0}});

  // a load while running restarts the full interval
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {W{1'b0}};
    end else if (load) begin
      count_reg <= LEN_W;
    end else if (busy) begin
      count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ### logic/hbgc_top.v
// gate control and protection logic for one h-bridge, outputs a and b, apb status
//
// How it works
// - enabled, not disabled, no fault: each output follows its polarity input
// - disable_high high tri-states both outputs; rest stays awake, no sleep
// - enable low tri-states outputs at once and enters sleep
// - bridge operates only while enable_or_disable_low is high
// - undriven enable input reads low, so sleep with outputs tri-stated
// - fault or disable shown by pulling fault_flag_n low while enabled, released high otherwise
// - under-voltage tri-states and flags low; clears itself on recovery
// - short or over-temperature latches outputs off and flag low
// - disable falling or enable rising clears the latch, flag high
// - without latched fault, outputs take the input-selected state
// - threshold hit tri-states for the off interval, then restarts
// - blanking restarts on each output transition; shorts still latch
// - above fold temperature the lower regulation threshold is used
// - over-temperature detect performs the latched shutdown
// - threshold is ignored during the blanking interval
// - over-temperature latch clears only once cooled below hysteresis
`timescale 1ns/1ps
`include "hbgc_defs.vh"
module hbgc_top #(
  parameter OFF_NS   = `HBGC_OFF_NS,
  parameter BLANK_NS = `HBGC_BLANK_NS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        polarity_in_a,
  input  wire        polarity_in_a_driven,
  input  wire        polarity_in_b,
  input  wire        polarity_in_b_driven,
  input  wire        disable_high,
  input  wire        disable_high_driven,
  input  wire        enable_or_disable_low,
  input  wire        enable_or_disable_low_driven,
  input  wire        undervoltage_det,
  input  wire        short_det,
  input  wire        overtemp_det,
  input  wire        temp_fold_det,
  input  wire        temp_cool_det,
  input  wire        current_over_normal,
  input  wire        current_over_fold,
  output reg         bridge_out_a,
  output reg         bridge_out_b,
  output reg         bridge_out_oe,
  output reg         fault_flag_n,
  output wire        fault_flag_n_oe,
  output reg         sleep_mode,
  output reg         current_reg_threshold,
  output wire        irq
);

  // least times round up to whole cycles, never below one
  localparam OFF_CYC   = (OFF_NS + `HBGC_CLK_PERIOD_NS - 1) /
                         `HBGC_CLK_PERIOD_NS;
  localparam BLANK_CYC = (BLANK_NS + `HBGC_CLK_PERIOD_NS - 1) /
                         `HBGC_CLK_PERIOD_NS;
  localparam OFF_LEN   = (OFF_CYC < 1) ? 1 : OFF_CYC;
  localparam BLANK_LEN = (BLANK_CYC < 1) ? 1 : BLANK_CYC;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  wire [14:0] pins_raw;
  wire [14:0] pins_s;

  assign pins_raw = {current_over_fold, current_over_normal, temp_cool_det,
                     temp_fold_det, overtemp_det, short_det,
                     undervoltage_det, enable_or_disable_low_driven,
                     enable_or_disable_low, disable_high_driven,
                     disable_high, polarity_in_b_driven, polarity_in_b,
                     polarity_in_a_driven, polarity_in_a};

  hbgc_sync #(
    .W (15)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  wire pol_a_eff;
  wire pol_b_eff;
  wire dis_eff;
  wire en_eff;
  wire uv_s;
  wire short_s;
  wire ot_s;
  wire fold_s;
  wire cool_s;
  wire over_normal_s;
  wire over_fold_s;

  assign pol_a_eff     = pins_s[1] ? pins_s[0] : 1'b1;
  assign pol_b_eff     = pins_s[3] ? pins_s[2] : 1'b1;
  assign dis_eff       = pins_s[5] ? pins_s[4] : 1'b1;
  assign en_eff        = pins_s[7] ? pins_s[6] : 1'b0;
  assign uv_s          = pins_s[8];
  assign short_s       = pins_s[9];
  assign ot_s          = pins_s[10];
  assign fold_s        = pins_s[11];
  assign cool_s        = pins_s[12];
  assign over_normal_s = pins_s[13];
  assign over_fold_s   = pins_s[14];

  ////////////////////////////////////////////////////////////////////////
  // fault latches and clear events

  reg  dis_prev_reg;
  reg  en_prev_reg;
  reg  sc_latch_reg;
  reg  ot_latch_reg;
  reg  force_off_reg;
  wire clear_evt;
  wire sc_set;
  wire ot_set;
  wire sc_next;
  wire ot_next;

  // disable falling or enable rising
  assign clear_evt = (dis_prev_reg & ~dis_eff) |
                     (~en_prev_reg & en_eff);

  // shorts are only meaningful while the stage drives
  assign sc_set = en_eff & bridge_out_oe & short_s;
  assign ot_set = en_eff & ot_s;

  // a new detection in the clearing cycle wins over the clear
  assign sc_next = (sc_latch_reg & ~clear_evt) | sc_set;
  // hot die keeps the latch even across a toggle
  assign ot_next = (ot_latch_reg & ~(clear_evt & cool_s)) |
                   ot_set;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_prev_reg <= 1'b1;
      en_prev_reg  <= 1'b0;
      sc_latch_reg <= 1'b0;
      ot_latch_reg <= 1'b0;
    end else begin
      dis_prev_reg <= dis_eff;
      en_prev_reg  <= en_eff;
      sc_latch_reg <= sc_next;
      ot_latch_reg <= ot_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output stage selection, blanking and off-time regulation

  wire off_busy;
  wire blank_busy;
  wire active;
  wire drive_on;
  wire out_a_next;
  wire out_b_next;
  wire out_oe_next;
  wire transition;
  wire over_thr;
  wire trip;

  // sleep and disable need no timer: gated from the synchronised pins
  assign active = en_eff & ~dis_eff & ~uv_s & ~sc_latch_reg &
                  ~ot_latch_reg & ~force_off_reg;
  assign drive_on    = active & ~off_busy;
  assign out_oe_next = drive_on;
  assign out_a_next  = drive_on & pol_a_eff;
  assign out_b_next  = drive_on & pol_b_eff;

  assign transition = (out_oe_next != bridge_out_oe) |
                      (out_a_next != bridge_out_a) |
                      (out_b_next != bridge_out_b);

  assign over_thr = fold_s ? over_fold_s : over_normal_s;
  // the threshold is blind while blanking runs
  assign trip = bridge_out_oe & drive_on & over_thr &
                ~blank_busy;

  hbgc_timer #(
    .W   (`HBGC_TIMER_W),
    .LEN (OFF_LEN)
  ) u_off (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (trip),
    .busy    (off_busy)
  );

  hbgc_timer #(
    .W   (`HBGC_TIMER_W),
    .LEN (BLANK_LEN)
  ) u_blank (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (transition),
    .busy    (blank_busy)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_out_a          <= 1'b0;
      bridge_out_b          <= 1'b0;
      bridge_out_oe         <= 1'b0;
      sleep_mode            <= 1'b1;
      current_reg_threshold <= 1'b0;
    end else begin
      bridge_out_a          <= out_a_next;
      bridge_out_b          <= out_b_next;
      bridge_out_oe         <= out_oe_next;
      sleep_mode            <= ~en_eff;
      current_reg_threshold <= fold_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault flag, open drain

  wire flag_n_next;

  assign flag_n_next = ~en_eff ? 1'b1 :
                       (sc_latch_reg | ot_latch_reg | uv_s |
                        dis_eff) ? 1'b0 : 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag_n <= 1'b1;
    end else begin
      fault_flag_n <= flag_n_next;
    end
  end

  assign fault_flag_n_oe = ~fault_flag_n;

  ////////////////////////////////////////////////////////////////////////
  // event capture for the interrupt

  reg  uv_prev_reg;
  reg  [`HBGC_EV_W-1:0] int_stat_reg;
  reg  [`HBGC_EV_W-1:0] int_mask_reg;
  wire [`HBGC_EV_W-1:0] ev;
  wire [`HBGC_EV_W-1:0] w1c;

  assign ev[`HBGC_EV_SC]    = sc_set & ~sc_latch_reg;
  assign ev[`HBGC_EV_OT]    = ot_set & ~ot_latch_reg;
  assign ev[`HBGC_EV_UV]    = uv_s & ~uv_prev_reg;
  assign ev[`HBGC_EV_TRIP]  = trip;
  assign ev[`HBGC_EV_CLEAR] = (sc_latch_reg | ot_latch_reg) &
                              ~sc_next & ~ot_next;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, read data registered in setup

  function is_mapped;
    input [11:0] a;
    begin
      if (a == `HBGC_ADDR_STATE) begin
        is_mapped = 1'b1;
      end else if (a == `HBGC_ADDR_INT_STAT) begin
        is_mapped = 1'b1;
      end else if (a == `HBGC_ADDR_INT_MASK) begin
        is_mapped = 1'b1;
      end else if (a == `HBGC_ADDR_CTRL) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction

  wire wr_acc;
  wire rd_setup;
  wire [`HBGC_ST_W-1:0] state_word;

  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~is_mapped(paddr);
  assign wr_acc   = psel & penable & pwrite & is_mapped(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;

  assign w1c = (wr_acc && paddr == `HBGC_ADDR_INT_STAT) ?
               pwdata[`HBGC_EV_W-1:0] : {`HBGC_EV_W{1'b0}};

  assign state_word = {fold_s, bridge_out_oe, bridge_out_b, bridge_out_a,
                       fault_flag_n, blank_busy, off_busy, uv_s,
                       ot_latch_reg, sc_latch_reg, active, sleep_mode};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_prev_reg   <= 1'b0;
      int_stat_reg  <= {`HBGC_EV_W{1'b0}};
      int_mask_reg  <= `HBGC_RST_INT_MASK;
      force_off_reg <= `HBGC_RST_CTRL;
      prdata        <= 32'h0000_0000;
    end else begin
      uv_prev_reg  <= uv_s;
      // set wins over a simultaneous write-one clear
      int_stat_reg <= (int_stat_reg & ~w1c) | ev;
      if (wr_acc && paddr == `HBGC_ADDR_INT_MASK) begin
        int_mask_reg <= pwdata[`HBGC_EV_W-1:0];
      end
      if (wr_acc && paddr == `HBGC_ADDR_CTRL) begin
        force_off_reg <= pwdata[`HBGC_CTRL_FORCE_OFF];
      end
      if (rd_setup) begin
        if (paddr == `HBGC_ADDR_STATE) begin
          prdata <= {{(32-`HBGC_ST_W){1'b0}}, state_word};
        end else if (paddr == `HBGC_ADDR_INT_STAT) begin
          prdata <= {{(32-`HBGC_EV_W){1'b0}}, int_stat_reg};
        end else if (paddr == `HBGC_ADDR_INT_MASK) begin
          prdata <= {{(32-`HBGC_EV_W){1'b0}}, int_mask_reg};
        end else if (paddr == `HBGC_ADDR_CTRL) begin
          prdata <= {31'h0000_0000, force_off_reg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

endmodule

// ### sim/hbgc_checker.sv
// concurrent checks on the gate control pins and outputs
`timescale 1ns/1ps
module hbgc_checker (
  input wire pclk,
  input wire presetn,
  input wire polarity_in_a,
  input wire polarity_in_a_driven,
  input wire polarity_in_b,
  input wire polarity_in_b_driven,
  input wire disable_high,
  input wire disable_high_driven,
  input wire enable_or_disable_low,
  input wire enable_or_disable_low_driven,
  input wire undervoltage_det,
  input wire short_det,
  input wire overtemp_det,
  input wire temp_fold_det,
  input wire bridge_out_a,
  input wire bridge_out_b,
  input wire bridge_out_oe,
  input wire fault_flag_n,
  input wire fault_flag_n_oe,
  input wire sleep_mode,
  input wire current_reg_threshold
);
  // effective levels: undriven pins read as their pull
  wire pa = polarity_in_a | ~polarity_in_a_driven;
  wire pb = polarity_in_b | ~polarity_in_b_driven;
  wire dh = disable_high | ~disable_high_driven;
  wire en = enable_or_disable_low & enable_or_disable_low_driven;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////
  property p_sleep; sleep_mode |-> !bridge_out_oe && fault_flag_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep state");
  // six edges cover the pin filter plus the output register
  property p_en_low; !en [*6] |-> sleep_mode; endproperty
  a_en_low: assert property (p_en_low) else $error("no sleep");
  // a low flag always comes with the stage tri-stated
  property p_flag_oe; !fault_flag_n
    |-> fault_flag_n_oe && !bridge_out_oe; endproperty
  a_flag_oe: assert property (p_flag_oe) else $error("flag drive");
  property p_dis; (dh && en) [*6]
    |-> !bridge_out_oe && !sleep_mode && !fault_flag_n; endproperty
  a_dis: assert property (p_dis) else $error("disable state");
  property p_out; $stable({pa, pb}) [*6] ##0 bridge_out_oe
    |-> {bridge_out_a, bridge_out_b} == {pa, pb}; endproperty
  a_out: assert property (p_out) else $error("output levels");
  property p_short; short_det && bridge_out_oe
    |-> ##[1:8] !bridge_out_oe && !fault_flag_n; endproperty
  a_short: assert property (p_short) else $error("short latch");
  property p_ot; overtemp_det && bridge_out_oe |-> ##[1:8] !bridge_out_oe;
  endproperty
  a_ot: assert property (p_ot) else $error("overtemp off");
  property p_uv; undervoltage_det [*6] |-> !bridge_out_oe; endproperty
  a_uv: assert property (p_uv) else $error("uv outputs");
  property p_fold; $stable(temp_fold_det) [*6]
    |-> current_reg_threshold == temp_fold_det; endproperty
  a_fold: assert property (p_fold) else $error("fold threshold");
endmodule

// ### sim/hbgc_host.sv
// host model: pin drivers with pulls, open-drain flag pull-up
`timescale 1ns/1ps
module hbgc_host (
  input  wire       pclk,
  input  wire [3:0] want_val,
  input  wire [3:0] want_drv,
  input  wire       fault_flag_n_oe,
  output reg  [3:0] pin,
  output reg  [3:0] pin_drv,
  output wire       flag_line
);
  // order {enable, disable, b, a}; released a, b, disable pull up
  localparam [3:0] PULL = 4'h7;
  initial begin
    pin     = PULL;
    pin_drv = 4'h0;
  end
  // gpio register: the host changes pins only after a clock edge
  always @(posedge pclk) begin
    pin_drv <= want_drv;
    pin     <= (want_val & want_drv) | (PULL & ~want_drv);
  end
  assign flag_line = fault_flag_n_oe ? 1'h0 : 1'h1;
endmodule

// ### sim/hbgc_tb_top.sv
// self-checking bench for the h-bridge gate control block
`timescale 1ns/1ps
`include "hbgc_defs.vh"
module hbgc_tb_top;
  localparam integer OFF_C = 200 / `HBGC_CLK_PERIOD_NS;
  localparam integer BLK_C = 150 / `HBGC_CLK_PERIOD_NS;
  reg         pclk, presetn, psel, penable, pwrite;
  reg  [11:0] paddr;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, flag_line, fault_flag_n_oe;
  reg  [3:0]  wv, wd;
  wire [3:0]  pin, pdrv;
  reg         undervoltage_det, short_det, overtemp_det, temp_fold_det;
  reg         temp_cool_det, current_over_normal, current_over_fold;
  wire        bridge_out_a, bridge_out_b, bridge_out_oe, fault_flag_n;
  wire        sleep_mode, current_reg_threshold;
  integer     errors, n_tests, n, i;
  hbgc_top #(.OFF_NS(200), .BLANK_NS(150)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .polarity_in_a(pin[0]),
    .polarity_in_a_driven(pdrv[0]), .polarity_in_b(pin[1]),
    .polarity_in_b_driven(pdrv[1]), .disable_high(pin[2]),
    .disable_high_driven(pdrv[2]), .enable_or_disable_low(pin[3]),
    .enable_or_disable_low_driven(pdrv[3]), .undervoltage_det, .short_det,
    .overtemp_det, .temp_fold_det, .temp_cool_det, .current_over_normal,
    .current_over_fold, .bridge_out_a, .bridge_out_b, .bridge_out_oe,
    .fault_flag_n, .fault_flag_n_oe, .sleep_mode, .current_reg_threshold,
    .irq);
  hbgc_host u_host (.pclk, .want_val(wv), .want_drv(wd), .fault_flag_n_oe,
    .pin, .pin_drv(pdrv), .flag_line);
////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ends on a falling edge so outputs have settled
  task tk(input integer c);
    repeat (c) @(posedge pclk);
    @(negedge pclk);
  endtask
  task st(input [3:0] v, input [3:0] d);
    @(posedge pclk);
    wv <= v;
    wd <= d;
    // a latch clear needs one edge more than a plain level change
    tk(7);
  endtask
  task ob(input [4:0] e);
    chk("pins", e, {sleep_mode, bridge_out_oe, bridge_out_a,
      bridge_out_b, flag_line});
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, e, input er);
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no wait-state count assumed; a hung slave is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    chk("pready", 1'h1, pready);
    chk("pslverr", er, pslverr);
    if (!w) chk("prdata", e, prdata);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'h1, a, d, 32'h0, 1'h0);
  endtask
  task rd(input [11:0] a, input [31:0] e);
    apb(1'h0, a, 32'h0, e, 1'h0);
  endtask
  task wt(input lv, input integer mx);
    n = 0;
    while (bridge_out_oe === lv && n < mx) begin
      @(negedge pclk);
      n = n + 1;
    end
  endtask
////////////////////////////////////////////////////////////////////////
  task t_reset;
    tk(8);
    ob(5'h11);
    rd(`HBGC_ADDR_STATE, 32'h81);
    rd(`HBGC_ADDR_INT_MASK, 32'h0);
    wr(`HBGC_ADDR_CTRL, 32'h1);
    rd(`HBGC_ADDR_CTRL, 32'h1);
    wr(`HBGC_ADDR_CTRL, 32'h0);
    apb(1'h0, 12'h010, 32'h0, 32'h0, 1'h1);
  endtask
  task t_modes;
    for (i = 0; i < 4; i = i + 1) begin
      st({2'h2, i[1:0]}, 4'hf);
      ob({2'h1, i[0], i[1], 1'h1});
    end
    st(4'h8, 4'hc);
    ob(5'h0f);
    st(4'hc, 4'hf);
    ob(5'h00);
    st(4'h8, 4'hb);
    ob(5'h00);
    st(4'h1, 4'hf);
    ob(5'h11);
    st(4'h9, 4'hf);
    ob(5'h0d);
    wr(`HBGC_ADDR_CTRL, 32'h1);
    tk(1);
    ob(5'h01);
    wr(`HBGC_ADDR_CTRL, 32'h0);
    tk(1);
    ob(5'h0d);
  endtask
  task t_uv;
    wr(`HBGC_ADDR_INT_STAT, 32'h1f);
    rd(`HBGC_ADDR_INT_STAT, 32'h0);
    @(posedge pclk);
    undervoltage_det <= 1'h1;
    tk(6);
    ob(5'h00);
    chk("irq masked", 1'h0, irq);
    wr(`HBGC_ADDR_INT_MASK, 32'h4);
    tk(1);
    chk("irq", 1'h1, irq);
    @(posedge pclk);
    undervoltage_det <= 1'h0;
    tk(6);
    ob(5'h0d);
    rd(`HBGC_ADDR_INT_STAT, 32'h4);
    wr(`HBGC_ADDR_INT_STAT, 32'h4);
    tk(1);
    chk("irq cleared", 1'h0, irq);
  endtask
  // two shorts cleared each way, then an overtemp that must cool first
  task t_latch;
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge pclk);
      short_det    <= (i < 2);
      overtemp_det <= (i == 2);
      tk(10);
      ob(5'h00);
      @(posedge pclk);
      short_det    <= 1'h0;
      overtemp_det <= 1'h0;
      st(4'ha, 4'hf);
      ob(5'h00);
      if (i == 2) begin
        st(4'he, 4'hf);
        st(4'ha, 4'hf);
        ob(5'h00);
        @(posedge pclk);
        temp_cool_det <= 1'h1;
      end
      st((i == 1) ? 4'h2 : 4'he, 4'hf);
      st(4'ha, 4'hf);
      ob(5'h0b);
      st(4'h9, 4'hf);
    end
    rd(`HBGC_ADDR_INT_STAT, 32'h13);
  endtask
  task t_reg;
    tk(OFF_C);
    @(posedge pclk);
    current_over_normal <= 1'h1;
    wt(1'h1, 40);
    wt(1'h0, 60);
    chk("off time", 1'h1, n >= OFF_C - 1 && n <= OFF_C + 2);
    wt(1'h1, 60);
    chk("blanking", 1'h1, n >= BLK_C && n <= BLK_C + 4);
    rd(`HBGC_ADDR_INT_STAT, 32'h1b);
    current_over_normal <= 1'h0;
    current_over_fold   <= 1'h1;
    tk(OFF_C + 8);
    wt(1'h1, 60);
    chk("no fold trip", 60, n);
    @(posedge pclk);
    temp_fold_det <= 1'h1;
    tk(0);
    wt(1'h1, 60);
    chk("fold trip", 1'h1, n <= BLK_C);
    chk("threshold", 1'h1, current_reg_threshold);
  endtask
  task report_and_stop;
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wv, wd} = 0;
    {undervoltage_det, short_det, overtemp_det, temp_fold_det} = 4'h0;
    {temp_cool_det, current_over_normal, current_over_fold} = 3'h0;
    errors  = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_modes;
    t_uv;
    t_latch;
    t_reg;
    report_and_stop;
  end
endmodule
bind hbgc_top hbgc_checker u_chk (.pclk, .presetn, .polarity_in_a,
  .polarity_in_a_driven, .polarity_in_b, .polarity_in_b_driven,
  .disable_high, .disable_high_driven, .enable_or_disable_low,
  .enable_or_disable_low_driven, .undervoltage_det, .short_det,
  .overtemp_det, .temp_fold_det, .bridge_out_a, .bridge_out_b,
  .bridge_out_oe, .fault_flag_n, .fault_flag_n_oe, .sleep_mode,
  .current_reg_threshold);
